//--- common/dmamb_cfg.svh
`ifndef DMAMB_CFG_SVH
`define DMAMB_CFG_SVH

// ==========================================================
// Controller register offsets (AHB-Lite, byte addresses)
`define DMAMB_OFS_CMD      8'h00
`define DMAMB_OFS_SRC      8'h04
`define DMAMB_OFS_DST      8'h08
`define DMAMB_OFS_TOTAL    8'h0c
`define DMAMB_OFS_CTRLA    8'h10
`define DMAMB_OFS_CTRLB    8'h14
`define DMAMB_OFS_SETUP    8'h18
`define DMAMB_OFS_FIRST    8'h1c
`define DMAMB_OFS_SOURCE_PICTURE_MODE_BIT     8'h20
`define DMAMB_OFS_DESTINATION_PICTURE_MODE_BIT     8'h24
`define DMAMB_OFS_CHAN     8'h28
`define DMAMB_OFS_STATUS   8'h2c

// Command register fields
`define DMAMB_CMD_START    0
`define DMAMB_CMD_MODE_LO  1
`define DMAMB_CMD_MODE_HI  2
`define DMAMB_CMD_STALL    3

// Status register fields
`define DMAMB_ST_BUSY      0
`define DMAMB_ST_DONE      1
`define DMAMB_ST_TAKEN     2
`define DMAMB_ST_CNT_LO    16

// ==========================================================
// Device register map
`define DMAMB_DEV_GLOBAL   32'h0000_0000
`define DMAMB_DEV_MASK_OFF 32'h0000_000c
`define DMAMB_DEV_UNMASK   32'h0000_0010
`define DMAMB_DEV_IRQ_ST   32'h0000_0014
`define DMAMB_DEV_ON       32'h0000_0018
`define DMAMB_DEV_STATE    32'h0000_001c
`define DMAMB_DEV_CH_BASE  32'h0000_0040
`define DMAMB_DEV_CH_STEP  32'h0000_0040
`define DMAMB_DEV_SRC      32'h0000_0000
`define DMAMB_DEV_DST      32'h0000_0004
`define DMAMB_DEV_DSCR     32'h0000_0008
`define DMAMB_DEV_CTRLA    32'h0000_000c
`define DMAMB_DEV_CTRLB    32'h0000_0010
`define DMAMB_DEV_SETUP    32'h0000_0014
`define DMAMB_DEV_SOURCE_PICTURE_MODE_BIT     32'h0000_0018
`define DMAMB_DEV_DESTINATION_PICTURE_MODE_BIT     32'h0000_001c

// Device bit positions
`define DMAMB_DEV_GLOBAL_EN  32'h0000_0001
`define DMAMB_DEV_KEEP_SH    8
`define DMAMB_DEV_PAUSE_SH   8
`define DMAMB_DEV_CHAIN_SH   8
`define DMAMB_DEV_AUTO_BIT   31
`define DMAMB_DEV_SOURCE_PICTURE_MODE_BIT_BIT   8
`define DMAMB_DEV_DESTINATION_PICTURE_MODE_BIT_BIT   12
`define DMAMB_DEV_SREP_BIT   8
`define DMAMB_DEV_DREP_BIT   12

`endif

//--- common/dmamb_pkg.sv
package dmamb_pkg;

    // ======================================================
    // Flow selection
    typedef enum logic [1:0] {
        DMAMB_RELOAD_BOTH,
        DMAMB_LIST_BOTH,
        DMAMB_RELOAD_SRC_LIST_DST,
        DMAMB_MODE_RSVD
    } dmamb_mode_t;

    // ======================================================
    // Sequencer states
    typedef enum logic [4:0] {
        S_IDLE,
        S_RD_STATE,
        S_RD_IRQ,
        S_WR_SRC,
        S_WR_DST,
        S_WR_CTRLA,
        S_WR_CTRLB,
        S_WR_SETUP,
        S_WR_DSCR,
        S_WR_SOURCE_PICTURE_MODE_BIT,
        S_WR_DESTINATION_PICTURE_MODE_BIT,
        S_WR_UNMASK,
        S_WR_GLOBAL,
        S_WR_ON,
        S_POLL,
        S_WR_AUTO,
        S_WR_SIZE,
        S_WR_KEEP,
        S_FIN
    } dmamb_state_t;

    // ======================================================
    // One device register access
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        write;
    } dmamb_dev_req_t;

endpackage

//--- hw/dmamb_dev_port.sv
module dmamb_dev_port (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    go,
    input  wire dmamb_pkg::dmamb_dev_req_t req,
    output      logic                    dev_valid,
    output      dmamb_pkg::dmamb_dev_req_t dev_req,
    input  wire logic                    dev_ack,
    input  wire logic [31:0]             dev_rdata,
    output      logic                    done,
    output      logic [31:0]             rdata
);

    // ======================================================
    // Hold the access until the device acknowledges it
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dev_valid <= 1'b0;
            dev_req   <= '0;
            done      <= 1'b0;
            rdata     <= 32'h0000_0000;
        end
        else
        begin
            done <= 1'b0;
            if (go && !dev_valid)
            begin
                dev_valid <= 1'b1;
                dev_req   <= req;
            end
            else if (dev_valid && dev_ack)
            begin
                dev_valid <= 1'b0;
                done      <= 1'b1;
                rdata     <= dev_rdata;
            end
        end
    end

endmodule

//--- hw/dmamb_host.sv
// The placing of the registers and register access over AHB-Lite were decided locally.
`include "dmamb_cfg.svh"

module dmamb_host #(
    parameter int SIZE_W = 16
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output      logic                      hreadyout,
    output      logic                      hresp,
    output      logic [31:0]               hrdata,
    output      logic                      dev_valid,
    output      dmamb_pkg::dmamb_dev_req_t dev_req,
    input  wire logic                      dev_ack,
    input  wire logic [31:0]               dev_rdata
);

    localparam logic [31:0] SIZE_MAX = 32'((64'h1 << SIZE_W) - 64'h1);

    // ======================================================
    // Declarations
    dmamb_pkg::dmamb_state_t   state;
    dmamb_pkg::dmamb_mode_t    mode;
    dmamb_pkg::dmamb_dev_req_t next_req;
    logic        stall_mode;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [31:0] total;
    logic [31:0] ctrla_img;
    logic [31:0] ctrlb_img;
    logic [31:0] setup_img;
    logic [31:0] first_dscr;
    logic [31:0] source_picture_mode_bit_img;
    logic [31:0] destination_picture_mode_bit_img;
    logic [2:0]  chan;
    logic        busy;
    logic        done_flag;
    logic        taken;
    logic [15:0] buf_cnt;
    logic [31:0] rem;
    logic        auto_on;
    logic        start;
    logic        wr_pend;
    logic [7:0]  wr_ofs;
    logic        issued;
    logic        acc_go;
    logic        acc_done;
    logic [31:0] acc_rdata;
    logic [31:0] ch_base;
    logic [31:0] ch_bit;
    logic [31:0] cur_size;
    logic [31:0] rem_after;
    logic [31:0] rd_mux;

    assign ch_base   = `DMAMB_DEV_CH_BASE + 32'(chan) * `DMAMB_DEV_CH_STEP;
    assign ch_bit    = 32'h0000_0001 << chan;
    assign cur_size  = (rem > SIZE_MAX) ? SIZE_MAX : rem;
    assign rem_after = rem - cur_size;

    // ======================================================
    // AHB-Lite slave, zero wait states
    always_comb
    begin
        case (haddr[7:0])
            `DMAMB_OFS_CMD:    rd_mux = {28'h000_0000, stall_mode, mode, 1'b0};
            `DMAMB_OFS_SRC:    rd_mux = src_addr;
            `DMAMB_OFS_DST:    rd_mux = dst_addr;
            `DMAMB_OFS_TOTAL:  rd_mux = total;
            `DMAMB_OFS_CTRLA:  rd_mux = ctrla_img;
            `DMAMB_OFS_CTRLB:  rd_mux = ctrlb_img;
            `DMAMB_OFS_SETUP:  rd_mux = setup_img;
            `DMAMB_OFS_FIRST:  rd_mux = first_dscr;
            `DMAMB_OFS_SOURCE_PICTURE_MODE_BIT:   rd_mux = source_picture_mode_bit_img;
            `DMAMB_OFS_DESTINATION_PICTURE_MODE_BIT:   rd_mux = destination_picture_mode_bit_img;
            `DMAMB_OFS_CHAN:   rd_mux = {29'h0000_0000, chan};
            `DMAMB_OFS_STATUS: rd_mux = {buf_cnt, 13'h0000, taken, done_flag, busy};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wr_pend   <= 1'b0;
            wr_ofs    <= 8'h00;
        end
        else
        begin
            wr_pend <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1])
            begin
                wr_ofs <= haddr[7:0];
                if (!hwrite)
                begin
                    hrdata <= rd_mux;
                end
            end
        end
    end

    assign start = wr_pend && (wr_ofs == `DMAMB_OFS_CMD) && hwdata[`DMAMB_CMD_START] && !busy;

    // ======================================================
    // Order registers, writable only while idle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode       <= dmamb_pkg::DMAMB_RELOAD_BOTH;
            stall_mode <= 1'b0;
            src_addr   <= 32'h0000_0000;
            dst_addr   <= 32'h0000_0000;
            total      <= 32'h0000_0000;
            ctrla_img  <= 32'h0000_0000;
            ctrlb_img  <= 32'h0000_0000;
            setup_img  <= 32'h0000_0000;
            first_dscr <= 32'h0000_0000;
            source_picture_mode_bit_img   <= 32'h0000_0000;
            destination_picture_mode_bit_img   <= 32'h0000_0000;
            chan       <= 3'h0;
        end
        else if (wr_pend && !busy)
        begin
            case (wr_ofs)
                `DMAMB_OFS_CMD:
                begin
                    mode       <= dmamb_pkg::dmamb_mode_t'(hwdata[`DMAMB_CMD_MODE_HI:`DMAMB_CMD_MODE_LO]);
                    stall_mode <= hwdata[`DMAMB_CMD_STALL];
                end
                `DMAMB_OFS_SRC:   src_addr   <= hwdata;
                `DMAMB_OFS_DST:   dst_addr   <= hwdata;
                `DMAMB_OFS_TOTAL: total      <= hwdata;
                `DMAMB_OFS_CTRLA: ctrla_img  <= hwdata;
                `DMAMB_OFS_CTRLB: ctrlb_img  <= hwdata;
                `DMAMB_OFS_SETUP: setup_img  <= hwdata;
                `DMAMB_OFS_FIRST: first_dscr <= hwdata;
                `DMAMB_OFS_SOURCE_PICTURE_MODE_BIT:  source_picture_mode_bit_img   <= hwdata;
                `DMAMB_OFS_DESTINATION_PICTURE_MODE_BIT:  destination_picture_mode_bit_img   <= hwdata;
                `DMAMB_OFS_CHAN:  chan       <= hwdata[2:0];
                default:          chan       <= chan;
            endcase
        end
    end

    // ======================================================
    // Access issued in each state
    always_comb
    begin
        next_req = '0;
        case (state)
            dmamb_pkg::S_RD_STATE:  next_req.addr = `DMAMB_DEV_STATE;
            dmamb_pkg::S_RD_IRQ:    next_req.addr = `DMAMB_DEV_IRQ_ST;
            dmamb_pkg::S_POLL:      next_req.addr = `DMAMB_DEV_IRQ_ST;
            dmamb_pkg::S_FIN:       next_req.addr = `DMAMB_DEV_STATE;
            dmamb_pkg::S_WR_SRC:    next_req = '{ch_base + `DMAMB_DEV_SRC, src_addr, 1'b1};
            dmamb_pkg::S_WR_DST:    next_req = '{ch_base + `DMAMB_DEV_DST, dst_addr, 1'b1};
            dmamb_pkg::S_WR_CTRLA:  next_req = '{ch_base + `DMAMB_DEV_CTRLA,
                                      {ctrla_img[31:SIZE_W], cur_size[SIZE_W-1:0]}, 1'b1};
            dmamb_pkg::S_WR_SIZE:   next_req = '{ch_base + `DMAMB_DEV_CTRLA,
                                      {ctrla_img[31:SIZE_W], cur_size[SIZE_W-1:0]}, 1'b1};
            dmamb_pkg::S_WR_CTRLB:  next_req = '{ch_base + `DMAMB_DEV_CTRLB,
                                      {auto_on, ctrlb_img[30:0]}, 1'b1};
            dmamb_pkg::S_WR_AUTO:   next_req = '{ch_base + `DMAMB_DEV_CTRLB,
                                      {1'b0, ctrlb_img[30:0]}, 1'b1};
            dmamb_pkg::S_WR_SETUP:
            begin
                next_req = '{ch_base + `DMAMB_DEV_SETUP, setup_img, 1'b1};
                next_req.wdata[`DMAMB_DEV_SREP_BIT] = (mode != dmamb_pkg::DMAMB_LIST_BOTH);
                next_req.wdata[`DMAMB_DEV_DREP_BIT] = (mode == dmamb_pkg::DMAMB_RELOAD_BOTH);
            end
            dmamb_pkg::S_WR_DSCR:   next_req = '{ch_base + `DMAMB_DEV_DSCR,
                                      (mode == dmamb_pkg::DMAMB_RELOAD_BOTH) ? 32'h0000_0000 : first_dscr, 1'b1};
            dmamb_pkg::S_WR_SOURCE_PICTURE_MODE_BIT:   next_req = '{ch_base + `DMAMB_DEV_SOURCE_PICTURE_MODE_BIT, source_picture_mode_bit_img, 1'b1};
            dmamb_pkg::S_WR_DESTINATION_PICTURE_MODE_BIT:   next_req = '{ch_base + `DMAMB_DEV_DESTINATION_PICTURE_MODE_BIT, destination_picture_mode_bit_img, 1'b1};
            dmamb_pkg::S_WR_UNMASK: next_req = '{stall_mode ? `DMAMB_DEV_UNMASK : `DMAMB_DEV_MASK_OFF,
                                      ch_bit, 1'b1};
            dmamb_pkg::S_WR_GLOBAL: next_req = '{`DMAMB_DEV_GLOBAL, `DMAMB_DEV_GLOBAL_EN, 1'b1};
            dmamb_pkg::S_WR_ON:     next_req = '{`DMAMB_DEV_ON, ch_bit, 1'b1};
            dmamb_pkg::S_WR_KEEP:   next_req = '{`DMAMB_DEV_ON, ch_bit << `DMAMB_DEV_KEEP_SH, 1'b1};
            default:     next_req = '0;
        endcase
    end

    // ======================================================
    // Sequencer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= dmamb_pkg::S_IDLE;
            issued    <= 1'b0;
            acc_go    <= 1'b0;
            busy      <= 1'b0;
            done_flag <= 1'b0;
            taken     <= 1'b0;
            buf_cnt   <= 16'h0000;
            rem       <= 32'h0000_0000;
            auto_on   <= 1'b0;
        end
        else
        begin
            acc_go <= 1'b0;
            if (state != dmamb_pkg::S_IDLE && !issued)
            begin
                acc_go <= 1'b1;
                issued <= 1'b1;
            end
            case (state)
                dmamb_pkg::S_IDLE:
                begin
                    if (start)
                    begin
                        busy      <= 1'b1;
                        done_flag <= 1'b0;
                        taken     <= 1'b0;
                        buf_cnt   <= 16'h0000;
                        rem       <= total;
                        auto_on   <= (dmamb_pkg::dmamb_mode_t'(hwdata[`DMAMB_CMD_MODE_HI:`DMAMB_CMD_MODE_LO]) ==
                                      dmamb_pkg::DMAMB_RELOAD_BOTH) && (total > SIZE_MAX);
                        state     <= dmamb_pkg::S_RD_STATE;
                    end
                end
                dmamb_pkg::S_POLL:
                begin
                    if (acc_done)
                    begin
                        issued <= 1'b0;
                        if (acc_rdata[chan + `DMAMB_DEV_CHAIN_SH])
                        begin
                            buf_cnt <= buf_cnt + 16'h0001;
                            state   <= dmamb_pkg::S_FIN;
                        end
                        else if (acc_rdata[chan])
                        begin
                            buf_cnt <= buf_cnt + 16'h0001;
                            rem     <= rem_after;
                            if (auto_on && rem_after <= SIZE_MAX)
                            begin
                                auto_on <= 1'b0;
                                state   <= dmamb_pkg::S_WR_AUTO;
                            end
                            else if (stall_mode)
                            begin
                                state <= dmamb_pkg::S_WR_KEEP;
                            end
                        end
                    end
                end
                dmamb_pkg::S_FIN:
                begin
                    if (acc_done)
                    begin
                        issued <= 1'b0;
                        if (!acc_rdata[chan])
                        begin
                            busy      <= 1'b0;
                            done_flag <= 1'b1;
                            state     <= dmamb_pkg::S_IDLE;
                        end
                    end
                end
                default:
                begin
                    if (acc_done)
                    begin
                        issued <= 1'b0;
                        case (state)
                            dmamb_pkg::S_RD_STATE:
                            begin
                                if (acc_rdata[chan])
                                begin
                                    taken <= 1'b1;
                                    busy  <= 1'b0;
                                    state <= dmamb_pkg::S_IDLE;
                                end
                                else
                                begin
                                    state <= dmamb_pkg::S_RD_IRQ;
                                end
                            end
                            dmamb_pkg::S_RD_IRQ:
                                state <= (mode == dmamb_pkg::DMAMB_LIST_BOTH) ?
                                         dmamb_pkg::S_WR_CTRLB : dmamb_pkg::S_WR_SRC;
                            dmamb_pkg::S_WR_SRC:
                                state <= (mode == dmamb_pkg::DMAMB_RELOAD_BOTH) ?
                                         dmamb_pkg::S_WR_DST : dmamb_pkg::S_WR_CTRLB;
                            dmamb_pkg::S_WR_DST:   state <= dmamb_pkg::S_WR_CTRLA;
                            dmamb_pkg::S_WR_CTRLA: state <= dmamb_pkg::S_WR_CTRLB;
                            dmamb_pkg::S_WR_CTRLB: state <= dmamb_pkg::S_WR_SETUP;
                            dmamb_pkg::S_WR_SETUP: state <= dmamb_pkg::S_WR_DSCR;
                            dmamb_pkg::S_WR_DSCR:
                                state <= ctrlb_img[`DMAMB_DEV_SOURCE_PICTURE_MODE_BIT_BIT] ? dmamb_pkg::S_WR_SOURCE_PICTURE_MODE_BIT :
                                         ctrlb_img[`DMAMB_DEV_DESTINATION_PICTURE_MODE_BIT_BIT] ? dmamb_pkg::S_WR_DESTINATION_PICTURE_MODE_BIT :
                                         dmamb_pkg::S_WR_UNMASK;
                            dmamb_pkg::S_WR_SOURCE_PICTURE_MODE_BIT:
                                state <= ctrlb_img[`DMAMB_DEV_DESTINATION_PICTURE_MODE_BIT_BIT] ? dmamb_pkg::S_WR_DESTINATION_PICTURE_MODE_BIT :
                                         dmamb_pkg::S_WR_UNMASK;
                            dmamb_pkg::S_WR_DESTINATION_PICTURE_MODE_BIT:
                                state <= dmamb_pkg::S_WR_UNMASK;
                            dmamb_pkg::S_WR_UNMASK: state <= dmamb_pkg::S_WR_GLOBAL;
                            dmamb_pkg::S_WR_GLOBAL: state <= dmamb_pkg::S_WR_ON;
                            dmamb_pkg::S_WR_ON:     state <= dmamb_pkg::S_POLL;
                            dmamb_pkg::S_WR_AUTO:
                                state <= !stall_mode ? dmamb_pkg::S_POLL :
                                         (cur_size != SIZE_MAX) ? dmamb_pkg::S_WR_SIZE : dmamb_pkg::S_WR_KEEP;
                            dmamb_pkg::S_WR_SIZE:   state <= dmamb_pkg::S_WR_KEEP;
                            dmamb_pkg::S_WR_KEEP:   state <= dmamb_pkg::S_POLL;
                            default:                state <= dmamb_pkg::S_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // ======================================================
    // Device register access port
    dmamb_dev_port u_port (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .go        (acc_go),
        .req       (next_req),
        .dev_valid (dev_valid),
        .dev_req   (dev_req),
        .dev_ack   (dev_ack),
        .dev_rdata (dev_rdata),
        .done      (acc_done),
        .rdata     (acc_rdata)
    );

endmodule

//--- dv/dmamb_dev_model.sv
// ==========================================================
// Device model: channel 0 register file and buffer engine
module dmamb_dev_model (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic                      slow,
    input  wire logic                      hog,
    input  wire logic                      dev_valid,
    input  wire dmamb_pkg::dmamb_dev_req_t dev_req,
    output      logic                      dev_ack,
    output      logic [31:0]               dev_rdata
);
    logic [31:0] r [0:31];
    logic [31:0] rd;
    logic [4:0]  a;
    logic [1:0]  w;
    logic [5:0]  t;
    assign a = dev_req.addr[6:2];
    // Released data lines show the inverse of the last word
    assign dev_rdata = dev_ack ? rd : ~rd;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '{default: '0};
            {rd, dev_ack, w, t} <= '0;
        end
        else
        begin
            dev_ack <= 1'b0;
            w <= (dev_valid && !dev_ack) ? w + 2'h1 : 2'h0;
            if (dev_valid && !dev_ack && (w == 2'h3 || !slow))
            begin
                dev_ack <= 1'b1;
                rd <= (a == 5'h07) ? (r[7] | {31'h0, hog}) : r[a];
                if (!dev_req.write && a == 5'h05)
                    r[5] <= '0;
                else if (dev_req.write && a == 5'h06)
                    r[7] <= (r[7] | {24'h0, dev_req.wdata[7:0]})
                        & ~{16'h0, dev_req.wdata[15:8], 8'h0};
                else if (dev_req.write && a == 5'h03)
                    r[4] <= r[4] & ~dev_req.wdata;
                else if (dev_req.write)
                    r[a] <= dev_req.wdata;
            end
            if (r[0][0] && r[7][0] && !r[7][8])
                t <= t + 6'h1;
            if (t == 6'h3c)
            begin
                t <= '0;
                r[5][0] <= 1'b1;
                if (!r[20][31])
                    {r[5][8], r[7][0]} <= 2'b10;
                else if (r[4][0])
                    r[7][8] <= 1'b1;
            end
        end
    end
endmodule

//--- dv/dmamb_host_assertions.sv
`include "dmamb_cfg.svh"
// ==========================================================
// Host port checks
module dmamb_host_assertions #(
    parameter int SIZE_W = 16
) (
    input wire logic                      sys_clk,
    input wire logic                      rst_n,
    input wire logic                      hreadyout,
    input wire logic                      hresp,
    input wire logic                      dev_valid,
    input wire dmamb_pkg::dmamb_dev_req_t dev_req,
    input wire logic                      dev_ack
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic acc, wr_on, on_w, keep_w, irq_r, gl_w, seen, glob;
    assign acc = dev_valid && dev_ack;
    assign wr_on = dev_valid && dev_req.write && dev_req.addr == `DMAMB_DEV_ON;
    assign on_w = wr_on && dev_req.wdata[7:0] != 8'h00;
    assign keep_w = wr_on && dev_req.wdata[15:8] != 8'h00;
    assign irq_r = !dev_req.write && dev_req.addr == `DMAMB_DEV_IRQ_ST;
    assign gl_w = dev_req.write && dev_req.addr == `DMAMB_DEV_GLOBAL && dev_req.wdata[0];
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            {seen, glob} <= 2'b00;
        else if (acc)
            {seen, glob} <= {irq_r || (seen && !on_w), glob || gl_w};
    host_ready_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    req_hold_a: assert property (dev_valid && !dev_ack |=> dev_valid) else $error("request dropped");
    req_stable_a: assert property (dev_valid && !dev_ack |=> $stable(dev_req)) else $error("request moved");
    access_gap_a: assert property (acc |=> !dev_valid [*2]) else $error("access gap short");
    global_first_a: assert property (on_w |-> glob) else $error("channel on before global");
    status_read_a: assert property (on_w |-> seen) else $error("channel on without status read");
    keep_order_a: assert property (keep_w |-> seen) else $error("keep without event read");
    cover property (keep_w && acc);
    cover property (on_w && acc);
    cover property (acc ##3 dev_valid);
endmodule
bind dmamb_host dmamb_host_assertions #(.SIZE_W(SIZE_W)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .hreadyout(hreadyout), .hresp(hresp), .dev_valid(dev_valid), .dev_req(dev_req), .dev_ack(dev_ack));

//--- dv/dmamb_host_tb_top.sv
`include "dmamb_cfg.svh"
// ==========================================================
// Bench top
module dmamb_host_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SW = 4;
    localparam logic [31:0] MX = (32'h1 << SW) - 32'h1;
    logic sys_clk, hreadyout, hresp, dev_valid, dev_ack;
    logic rst_n = 1'b0, hwrite = 1'b0, slow = 1'b0, hog = 1'b0;
    logic [1:0] htrans = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, dev_rdata;
    dmamb_pkg::dmamb_dev_req_t dev_req;
    int err_total = 0, checked = 0;
    dmamb_host #(.SIZE_W(SW)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dev_valid(dev_valid),
        .dev_req(dev_req), .dev_ack(dev_ack), .dev_rdata(dev_rdata));
    dmamb_dev_model u_dev (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .hog(hog),
        .dev_valid(dev_valid), .dev_req(dev_req), .dev_ack(dev_ack), .dev_rdata(dev_rdata));
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
        haddr <= {24'h0, ad};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask
    task automatic poll(input int b, output logic [31:0] d);
        d = '0;
        for (int k = 0; k < 3000 && !(d[b] === 1'b1 && d[0] === 1'b0); k++)
            ahb(1'b0, `DMAMB_OFS_STATUS, '0, d);
    endtask
    task automatic run(input logic [1:0] m, input logic st, input logic [31:0] tot, input logic [15:0] n);
        logic [31:0] d;
        ahb(1'b1, `DMAMB_OFS_TOTAL, tot, d);
        ahb(1'b1, `DMAMB_OFS_CTRLB, 32'h0, d);
        ahb(1'b1, `DMAMB_OFS_CMD, {28'h0, st, m, 1'b1}, d);
        poll(1, d);
        chk("done", 32'h1, {31'h0, d[1]});
        chk("buffers", {16'h0, n}, {16'h0, d[31:16]});
        $display("test mode %0d stall %0d finished", m, st);
    endtask
    task automatic misc_test;
        logic [31:0] d;
        ahb(1'b0, `DMAMB_OFS_STATUS, '0, d);
        chk("status after reset", 32'h0, d);
        ahb(1'b0, 8'h30, '0, d);
        chk("unmapped read", 32'h0, d);
        hog <= 1'b1;
        ahb(1'b1, `DMAMB_OFS_CMD, 32'h1, d);
        poll(2, d);
        chk("taken", 32'h1, {31'h0, d[2]});
        chk("global untouched", 32'h0, u_dev.r[0]);
        hog <= 1'b0;
        $display("test registers and busy channel finished");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        misc_test;
        run(2'h0, 1'b0, MX, 16'h1);
        slow <= 1'b1;
        run(2'h0, 1'b1, MX * 32'h3, 16'h3);
        slow <= 1'b0;
        run(2'h0, 1'b0, MX * 32'h2, 16'h2);
        run(2'h1, 1'b0, 32'ha, 16'h1);
        run(2'h2, 1'b1, 32'ha, 16'h1);
        conclude;
    end
    initial
    begin
        #2000000;
        err_total++;
        conclude;
    end
endmodule
